// ===== acs_sequencer.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// sample fifo between converter and sample buffer
// ------------------------------------------------------------
module acs_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [W-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [W-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;
  // pointers and fill count
  always_comb begin
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  // storage has no reset, contents only read when counted valid
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_r] <= in_data_in;
    end
  end
  assign in_ready_out = (cnt_r != DEPTH[AW:0]);
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem[rp_r];
endmodule // acs_fifo

module acs_sequencer (
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // peripheral register bus
  input wire logic [4:0] reg_index_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  // converter request
  output logic conv_start_out,
  output logic [1:0] conv_ref_sel_out,
  output logic [8:0] conv_acq_extend_out,
  output logic conv_diff_out,
  output logic [2:0] conv_input_out,
  // converter answer
  input wire logic conv_done_in,
  input wire logic [11:0] conv_result_in,
  // analog enables
  output logic temp_sensor_on_out,
  output logic internal_ref_on_out
);
  import acs_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] setup_r [8];
  logic [15:0] sample_buffer [16];
  logic [15:0] ctrl_r, ctrl_nxt, bounds_r, bounds_nxt;
  logic [7:0] temp_r, temp_nxt;
  logic [4:0] index_r, index_nxt;
  logic running_r, running_nxt, ready_r, ready_nxt;
  logic [3:0] last_wr_r, last_wr_nxt, store_r, store_nxt;
  logic [2:0] cur_r, cur_nxt;
  logic [15:0] rdata_nxt;
  logic start_nxt;
  logic [1:0] ref_nxt;
  logic [8:0] acq_nxt;
  logic diff_nxt;
  logic [2:0] inp_nxt;
  logic align_r, align_nxt;
  acs_state_e state_r, state_nxt;
  logic port_hit, setup_wr, buf_wr_sw;
  logic [15:0] cur_setup, push_data, port_rd;
  logic push, fifo_room, drain_valid, drain_ready;
  logic [15:0] drain_data;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // port reads and writes take the entry under the index, then step it
  always_comb begin
    port_hit = (reg_wr_in || reg_rd_in) && (reg_index_in == ACS_IDX_PORT);
    setup_wr = reg_wr_in && (reg_index_in == ACS_IDX_PORT) && !running_r
               && (index_r >= ACS_PORT_SETUP_FIRST) && (index_r <= ACS_PORT_SETUP_LAST);
    buf_wr_sw = reg_wr_in && (reg_index_in == ACS_IDX_PORT)
                && (index_r <= ACS_PORT_BUF_LAST);
    port_rd = 16'h0000;
    if (index_r <= ACS_PORT_BUF_LAST) begin
      port_rd = sample_buffer[index_r[3:0]];
    end else if (index_r <= ACS_PORT_SETUP_LAST) begin
      port_rd = setup_r[index_r[2:0]] & ACS_SETUP_MASK;
    end
    case (reg_index_in)
      ACS_IDX_CTRL: rdata_nxt = ctrl_r;
      ACS_IDX_STATUS: rdata_nxt = {4'h0, last_wr_r, 1'b0, running_r, ready_r, index_r};
      ACS_IDX_PORT: rdata_nxt = port_rd;
      ACS_IDX_BOUNDS: rdata_nxt = bounds_r;
      ACS_IDX_TEMP: rdata_nxt = {8'h00, temp_r};
      default: rdata_nxt = 16'h0000;
    endcase
    if (!reg_rd_in) begin
      rdata_nxt = 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // software registers and the port index
  // ------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    bounds_nxt = bounds_r;
    temp_nxt = temp_r;
    index_nxt = index_r;
    if (reg_wr_in && reg_index_in == ACS_IDX_CTRL) begin
      ctrl_nxt = reg_wdata_in & ACS_CTRL_MASK;
    end
    if (reg_wr_in && reg_index_in == ACS_IDX_BOUNDS) begin
      bounds_nxt = reg_wdata_in & ACS_BOUNDS_MASK;
    end
    if (reg_wr_in && reg_index_in == ACS_IDX_TEMP) begin
      temp_nxt = {7'h00, reg_wdata_in[ACS_TEMP_ON]};
    end
    if (reg_wr_in && reg_index_in == ACS_IDX_STATUS) begin
      index_nxt = reg_wdata_in[4:0];
    end else if (port_hit) begin
      index_nxt = index_r + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // one conversion outstanding; a slot in the fifo is reserved before issue
  always_comb begin
    cur_setup = setup_r[cur_r];
    state_nxt = state_r;
    cur_nxt = cur_r;
    store_nxt = store_r;
    running_nxt = running_r;
    ready_nxt = ready_r;
    start_nxt = 1'b0;
    ref_nxt = conv_ref_sel_out;
    acq_nxt = conv_acq_extend_out;
    diff_nxt = conv_diff_out;
    inp_nxt = conv_input_out;
    align_nxt = align_r;
    push = 1'b0;
    // drain advances the store pointer; a fresh start below overrides it
    if (drain_valid && drain_ready) begin
      store_nxt = store_r + 4'h1;
    end
    // software side of the flags: clears first so hardware sets win
    if (reg_wr_in && reg_index_in == ACS_IDX_STATUS) begin
      running_nxt = reg_wdata_in[ACS_ST_RUN];
      if (!reg_wdata_in[ACS_ST_READY]) begin
        ready_nxt = 1'b0;
      end
    end
    case (state_r)
      ACS_S_IDLE: begin
        if (running_r) begin
          cur_nxt = bounds_r[6:4];
          store_nxt = bounds_r[11:8];
          state_nxt = ACS_S_ISSUE;
        end
      end
      ACS_S_ISSUE: begin
        if (!running_r) begin
          state_nxt = ACS_S_IDLE;
        end else if (fifo_room) begin
          start_nxt = 1'b1;
          if (!cur_setup[ACS_SETUP_REF]) begin
            ref_nxt = ACS_REF_SUPPLY;
          end else if (ctrl_r[ACS_CTRL_IREF]) begin
            ref_nxt = ACS_REF_INTERNAL;
          end else begin
            ref_nxt = ACS_REF_EXTERNAL;
          end
          acq_nxt = cur_setup[ACS_SETUP_ACQ]
                    ? ACS_ACQ_UNIT * ({5'h00, ctrl_r[3:0]} + 9'h001) : 9'h000;
          diff_nxt = cur_setup[ACS_SETUP_DIFF];
          // differential drops the top select bit
          inp_nxt = cur_setup[ACS_SETUP_DIFF]
                    ? {1'b0, cur_setup[1:0]} : cur_setup[2:0];
          align_nxt = cur_setup[ACS_SETUP_ALIGN];
          state_nxt = ACS_S_WAIT;
        end
      end
      ACS_S_WAIT: begin
        if (conv_done_in) begin
          push = 1'b1;
          if (cur_r == bounds_r[2:0]) begin
            ready_nxt = 1'b1;
            cur_nxt = bounds_r[6:4];
            if (!ctrl_r[ACS_CTRL_CONT]) begin
              running_nxt = 1'b0;
            end
          end else begin
            cur_nxt = cur_r + 3'h1;
          end
          state_nxt = ACS_S_ISSUE;
        end
      end
      default: state_nxt = ACS_S_IDLE;
    endcase
    // software start in the very cycle of the hardware clear still starts
    if (reg_wr_in && reg_index_in == ACS_IDX_STATUS && reg_wdata_in[ACS_ST_RUN]) begin
      running_nxt = 1'b1;
    end
  end

  // result formatting per the latched setup of this conversion
  always_comb begin
    if (align_r) begin
      push_data = {conv_result_in, 4'h0};
    end else if (conv_diff_out) begin
      push_data = {{4{conv_result_in[11]}}, conv_result_in};
    end else begin
      push_data = {4'h0, conv_result_in};
    end
  end

  // drain stalls while software owns the port this cycle
  always_comb begin
    drain_ready = !port_hit;
    last_wr_nxt = (drain_valid && drain_ready) ? store_r : last_wr_r;
  end

  acs_fifo #(
    .W(ACS_FIFO_W),
    .DEPTH(ACS_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(push),
    .in_data_in(push_data),
    .in_ready_out(fifo_room),
    .out_valid_out(drain_valid),
    .out_data_out(drain_data),
    .out_ready_in(drain_ready)
  );

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl_r <= 16'h0000;
      bounds_r <= 16'h0000;
      temp_r <= ACS_TEMP_RST;
      index_r <= 5'h00;
      running_r <= 1'b0;
      ready_r <= 1'b0;
      last_wr_r <= 4'h0;
      store_r <= 4'h0;
      cur_r <= 3'h0;
      state_r <= ACS_S_IDLE;
      align_r <= 1'b0;
      reg_rdata_out <= 16'h0000;
      conv_start_out <= 1'b0;
      conv_ref_sel_out <= ACS_REF_SUPPLY;
      conv_acq_extend_out <= 9'h000;
      conv_diff_out <= 1'b0;
      conv_input_out <= 3'h0;
      temp_sensor_on_out <= 1'b0;
      internal_ref_on_out <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        setup_r[i] <= ACS_SETUP_RST;
      end
      for (int i = 0; i < 16; i++) begin
        sample_buffer[i] <= 16'h0000;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      bounds_r <= bounds_nxt;
      temp_r <= temp_nxt;
      index_r <= index_nxt;
      running_r <= running_nxt;
      ready_r <= ready_nxt;
      last_wr_r <= last_wr_nxt;
      store_r <= store_nxt;
      cur_r <= cur_nxt;
      state_r <= state_nxt;
      align_r <= align_nxt;
      reg_rdata_out <= rdata_nxt;
      conv_start_out <= start_nxt;
      conv_ref_sel_out <= ref_nxt;
      conv_acq_extend_out <= acq_nxt;
      conv_diff_out <= diff_nxt;
      conv_input_out <= inp_nxt;
      temp_sensor_on_out <= temp_nxt[ACS_TEMP_ON];
      internal_ref_on_out <= ctrl_nxt[ACS_CTRL_IREF];
      if (setup_wr) begin
        setup_r[index_r[2:0]] <= reg_wdata_in & ACS_SETUP_MASK;
      end
      if (buf_wr_sw) begin
        sample_buffer[index_r[3:0]] <= reg_wdata_in;
      end else if (drain_valid && drain_ready) begin
        sample_buffer[store_r] <= drain_data;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  logic [15:0] setup_watch;
  assign setup_watch = setup_r[index_r[2:0]];
  property p_setup_locked;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_index_in == ACS_IDX_PORT && running_r && index_r[4])
      |=> setup_r[$past(index_r[2:0])] == $past(setup_watch);
  endproperty
  a_setup_locked: assert property (p_setup_locked) else $error("setup changed while running");
  property p_point_setup;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_index_in == ACS_IDX_STATUS && reg_wdata_in == 16'h0010)
      |=> index_r == 5'h10;
  endproperty
  a_point_setup: assert property (p_point_setup) else $error("index not at setup 0");
  property p_temp_follow;
    @(posedge clk_in) disable iff (!resetn_in)
      (reg_wr_in && reg_index_in == ACS_IDX_TEMP)
      |=> temp_sensor_on_out == $past(reg_wdata_in[0]) && temp_r[7:1] == 7'h00;
  endproperty
  a_temp_follow: assert property (p_temp_follow) else $error("sensor enable wrong");
  sequence s_last_done;
    state_r == ACS_S_WAIT && conv_done_in && cur_r == bounds_r[2:0];
  endsequence
  sequence s_no_sw_status;
    !(reg_wr_in && reg_index_in == ACS_IDX_STATUS);
  endsequence
  property p_single_end;
    @(posedge clk_in) disable iff (!resetn_in)
      s_last_done and s_no_sw_status and !ctrl_r[ACS_CTRL_CONT] |=> !running_r && ready_r;
  endproperty
  a_single_end: assert property (p_single_end) else $error("sequence end not flagged");
  property p_ready_set;
    @(posedge clk_in) disable iff (!resetn_in) s_last_done |=> ready_r;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("data flag not set");
  property p_right_align;
    @(posedge clk_in) disable iff (!resetn_in)
      push && !align_r |-> push_data[11:0] == conv_result_in
        && push_data[15:12] == (conv_diff_out ? {4{conv_result_in[11]}} : 4'h0);
  endproperty
  a_right_align: assert property (p_right_align) else $error("right align wrong");
  property p_left_align;
    @(posedge clk_in) disable iff (!resetn_in)
      push && align_r |-> push_data[3:0] == 4'h0 && push_data[15:4] == conv_result_in;
  endproperty
  a_left_align: assert property (p_left_align) else $error("left align wrong");
  property p_acq_len;
    @(posedge clk_in) disable iff (!resetn_in)
      start_nxt |=> conv_acq_extend_out ==
        ($past(cur_setup[ACS_SETUP_ACQ]) ? 9'd16 * ({5'h00, $past(ctrl_r[3:0])} + 9'd1) : 9'd0);
  endproperty
  a_acq_len: assert property (p_acq_len) else $error("acquisition extension wrong");
  property p_ref_pick;
    @(posedge clk_in) disable iff (!resetn_in)
      start_nxt && cur_setup[ACS_SETUP_REF] && !ctrl_r[ACS_CTRL_IREF]
      |=> conv_ref_sel_out == ACS_REF_EXTERNAL;
  endproperty
  a_ref_pick: assert property (p_ref_pick) else $error("reference choice wrong");
  property p_issue_wait;
    @(posedge clk_in) disable iff (!resetn_in)
      conv_start_out |-> state_r == ACS_S_WAIT ##1 !conv_start_out;
  endproperty
  a_issue_wait: assert property (p_issue_wait) else $error("start not single pulse");
endmodule // acs_sequencer

// ===== acs_pkg.sv
package acs_pkg;
  // ------------------------------------------------------------
  // register indices on the peripheral register bus
  // ------------------------------------------------------------
  localparam logic [4:0] ACS_IDX_CTRL = 5'h06;
  localparam logic [4:0] ACS_IDX_STATUS = 5'h08;
  localparam logic [4:0] ACS_IDX_PORT = 5'h09;
  localparam logic [4:0] ACS_IDX_BOUNDS = 5'h0a;
  localparam logic [4:0] ACS_IDX_TEMP = 5'h0c;
  // ------------------------------------------------------------
  // indirect port targets
  // ------------------------------------------------------------
  localparam logic [4:0] ACS_PORT_SETUP_FIRST = 5'h10;
  localparam logic [4:0] ACS_PORT_SETUP_LAST = 5'h17;
  localparam logic [4:0] ACS_PORT_BUF_LAST = 5'h0f;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int ACS_SETUP_REF = 6;
  localparam int ACS_SETUP_ACQ = 5;
  localparam int ACS_SETUP_ALIGN = 4;
  localparam int ACS_SETUP_DIFF = 3;
  localparam int ACS_ST_READY = 5;
  localparam int ACS_ST_RUN = 6;
  localparam int ACS_CTRL_IREF = 7;
  localparam int ACS_CTRL_CONT = 6;
  localparam int ACS_TEMP_ON = 0;
  // ------------------------------------------------------------
  // reset values and masks
  // ------------------------------------------------------------
  localparam logic [15:0] ACS_SETUP_RST = 16'h0000;
  localparam logic [15:0] ACS_SETUP_MASK = 16'h007f;
  localparam logic [7:0] ACS_TEMP_RST = 8'h00;
  localparam logic [15:0] ACS_CTRL_MASK = 16'h00cf;
  localparam logic [15:0] ACS_BOUNDS_MASK = 16'h0f77;
  // ------------------------------------------------------------
  // timing: extension unit in converter clocks
  // ------------------------------------------------------------
  localparam logic [8:0] ACS_ACQ_UNIT = 9'h010;
  // reference encodings
  localparam logic [1:0] ACS_REF_SUPPLY = 2'h0;
  localparam logic [1:0] ACS_REF_INTERNAL = 2'h1;
  localparam logic [1:0] ACS_REF_EXTERNAL = 2'h2;
  // sample fifo shape
  localparam int ACS_FIFO_DEPTH = 8;
  localparam int ACS_FIFO_W = 16;
  typedef enum logic [1:0] {ACS_S_IDLE, ACS_S_ISSUE, ACS_S_WAIT} acs_state_e;
endpackage

// ===== acs_sequencer_tb.sv
`timescale 1ns/1ps
module acs_sequencer_tb;
  import acs_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] reg_index_in = 5'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic [15:0] reg_rdata_out;
  logic conv_start_out;
  logic [1:0] conv_ref_sel_out;
  logic [8:0] conv_acq_extend_out;
  logic conv_diff_out;
  logic [2:0] conv_input_out;
  logic conv_done_in = 1'b0;
  logic [11:0] conv_result_in = 12'h000;
  logic temp_sensor_on_out;
  logic internal_ref_on_out;
  int n_fail = 0;
  int n_compared = 0;
  int n_conv = 0;
  int wait_cnt = 0;
  int cycles = 0;
  logic [14:0] cap[$];
  logic [15:0] rd_v;
  // entries cover every ref, align, diff and a spread of input codes
  logic [6:0] ent[8] = '{7'h06, 7'h7e, 7'h49, 7'h20, 7'h05, 7'h18, 7'h0a, 7'h03};

  acs_sequencer acs_sequencer_i (
    .clk_in(clk_in), .resetn_in(resetn_in),
    .reg_index_in(reg_index_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .conv_start_out(conv_start_out), .conv_ref_sel_out(conv_ref_sel_out),
    .conv_acq_extend_out(conv_acq_extend_out), .conv_diff_out(conv_diff_out),
    .conv_input_out(conv_input_out), .conv_done_in(conv_done_in),
    .conv_result_in(conv_result_in), .temp_sensor_on_out(temp_sensor_on_out),
    .internal_ref_on_out(internal_ref_on_out)
  );

  // 200 MHz clock
  always #2.5 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // converter stand-in: answers three cycles after each start
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    conv_done_in <= 1'b0;
    if (conv_start_out === 1'b1) begin
      cap.push_back({conv_ref_sel_out, conv_acq_extend_out, conv_diff_out, conv_input_out});
      wait_cnt <= 3;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
      if (wait_cnt == 1) begin
        conv_done_in <= 1'b1;
        conv_result_in <= 12'h9a0 + 12'(n_conv); // bit 11 set to expose sign copies
        n_conv++;
      end
    end
  end

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // bus tasks and expectations
  // ------------------------------------------------------------
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] d);
    @(posedge clk_in);
    reg_index_in <= i;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    // outputs launched by this edge settle before any caller looks
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [4:0] i, output logic [15:0] d);
    @(posedge clk_in);
    reg_index_in <= i;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [4:0] i, input logic [15:0] exp);
    rd(i, rd_v);
    chk(rd_v, exp);
  endtask

  // poll status until the sequence ends, bounded
  task automatic wait_idle;
    for (int k = 0; k < 200; k++) begin
      rd(ACS_IDX_STATUS, rd_v);
      if (rd_v[ACS_ST_RUN] === 1'b0) break;
    end
    // last sample lands in the buffer a cycle after running drops
    rd(ACS_IDX_STATUS, rd_v);
  endtask

  function automatic logic [15:0] fmt(input logic [11:0] r, input logic [6:0] e);
    if (e[ACS_SETUP_ALIGN]) return {r, 4'h0};
    if (e[ACS_SETUP_DIFF]) return {{4{r[11]}}, r};
    return {4'h0, r};
  endfunction

  function automatic logic [14:0] exp_set(input logic [6:0] e, input logic iref,
                                          input logic [3:0] cnt);
    logic [1:0] rf;
    logic [8:0] acq;
    rf = !e[ACS_SETUP_REF] ? ACS_REF_SUPPLY : (iref ? ACS_REF_INTERNAL : ACS_REF_EXTERNAL);
    acq = e[ACS_SETUP_ACQ] ? 9'(ACS_ACQ_UNIT * ({5'h00, cnt} + 9'h001)) : 9'h000;
    return {rf, acq, e[ACS_SETUP_DIFF], e[ACS_SETUP_DIFF] ? {1'b0, e[1:0]} : e[2:0]};
  endfunction

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    rchk(ACS_IDX_TEMP, 16'h0000);
    rchk(ACS_IDX_STATUS, 16'h0000);
    rchk(5'h1f, 16'h0000);
    wr(ACS_IDX_TEMP, 16'hffff);
    rchk(ACS_IDX_TEMP, 16'h0001);
    chk({15'h0000, temp_sensor_on_out}, 16'h0001);
    wr(ACS_IDX_TEMP, 16'h0000);
    chk({15'h0000, temp_sensor_on_out}, 16'h0000);
    // setup entries, reserved bits driven high on purpose
    wr(ACS_IDX_STATUS, 16'h0010);
    rchk(ACS_IDX_PORT, 16'h0000);
    wr(ACS_IDX_STATUS, 16'h0010);
    for (int k = 0; k < 8; k++) wr(ACS_IDX_PORT, {9'h1ff, ent[k]});
    wr(ACS_IDX_STATUS, 16'h0010);
    for (int k = 0; k < 8; k++) rchk(ACS_IDX_PORT, {9'h000, ent[k]});
    rchk(ACS_IDX_STATUS, 16'h0018);
    // full eight-entry scan, internal reference on, count 3
    wr(ACS_IDX_CTRL, 16'h0083);
    rchk(ACS_IDX_CTRL, 16'h0083);
    chk({15'h0000, internal_ref_on_out}, 16'h0001);
    wr(ACS_IDX_BOUNDS, 16'h0007);
    wr(ACS_IDX_STATUS, 16'h0040);
    wait_idle();
    chk(rd_v, 16'h0720);
    chk(16'(cap.size()), 16'h0008);
    for (int k = 0; k < 8; k++) chk({1'b0, cap[k]}, {1'b0, exp_set(ent[k], 1'b1, 4'h3)});
    wr(ACS_IDX_STATUS, 16'h0000);
    for (int k = 0; k < 8; k++) rchk(ACS_IDX_PORT, fmt(12'h9a0 + 12'(k), ent[k]));
    rchk(ACS_IDX_STATUS, 16'h0708);
    // two-entry scan, internal reference off, setup write while running
    wr(ACS_IDX_CTRL, 16'h0003);
    chk({15'h0000, internal_ref_on_out}, 16'h0000);
    wr(ACS_IDX_BOUNDS, 16'h0801);
    wr(ACS_IDX_STATUS, 16'h0050);
    wr(ACS_IDX_PORT, 16'h007f);
    wait_idle();
    chk(rd_v, 16'h0931);
    chk(16'(cap.size()), 16'h000a);
    chk({1'b0, cap[8]}, {1'b0, exp_set(ent[0], 1'b0, 4'h3)});
    chk({1'b0, cap[9]}, {1'b0, exp_set(ent[1], 1'b0, 4'h3)});
    wr(ACS_IDX_STATUS, 16'h0010);
    rchk(ACS_IDX_PORT, 16'h0006);
    wr(ACS_IDX_STATUS, 16'h0008);
    rchk(ACS_IDX_PORT, fmt(12'h9a8, ent[0]));
    rchk(ACS_IDX_PORT, fmt(12'h9a9, ent[1]));
    // continuous mode keeps running past the end of each pass
    wr(ACS_IDX_CTRL, 16'h0040);
    wr(ACS_IDX_BOUNDS, 16'h0000);
    wr(ACS_IDX_STATUS, 16'h0040);
    for (int k = 0; k < 50; k++) begin
      rd(ACS_IDX_STATUS, rd_v);
      if (rd_v[ACS_ST_READY] === 1'b1) break;
    end
    chk(rd_v & 16'h0060, 16'h0060);
    wr(ACS_IDX_STATUS, 16'h0000);
    wait_idle();
    chk({15'h0000, rd_v[ACS_ST_RUN]}, 16'h0000);
    conclude();
  end
endmodule // acs_sequencer_tb
